/* File: rtl/pfm_cfg.svh */
/*
 * Constants of the limit monitor: command codes, status bit positions,
 * reset words and Linear-format field positions.
 * Assumes it is included by its bare name wherever the numbers are needed.
 */
`ifndef PFM_CFG_SVH
`define PFM_CFG_SVH

// Command codes
`define PFM_CMD_STORE_ALL    8'h11
`define PFM_CMD_OT_WARN      8'h51
`define PFM_CMD_VIN_OV       8'h55
`define PFM_CMD_IIN_OC       8'h5B
`define PFM_CMD_STATUS_BYTE  8'h78
`define PFM_CMD_STATUS_WORD  8'h79
`define PFM_CMD_STATUS_INPUT 8'h7C
`define PFM_CMD_STATUS_TEMP  8'h7D

// Linear format fields
`define PFM_EXP_MSB          15
`define PFM_EXP_LSB          11
`define PFM_MANT_MSB         10

// Reset words, strap word and store-all base
`define PFM_OT_WARN_RST      16'h005F
`define PFM_VIN_OV_RST       16'h0011
`define PFM_VIN_OV_STRAP     16'h000E
`define PFM_IIN_OC_RST       16'h00FF
`define PFM_VIN_OV_BASE      16'h000E

// Status bit positions
`define PFM_SB_OTHER         0
`define PFM_SB_TEMP          2
`define PFM_SW_INPUT         13
`define PFM_SI_VIN_OV        7
`define PFM_SI_IIN_OC        2
`define PFM_ST_OT_WARN       6

`endif

/* File: rtl/pfm_fault_limit_monitor.sv */
/*
 * Limit registers and fault / warning flagging for over-temperature
 * warning, input overvoltage fault and input overcurrent fault.
 * Assumes a decoded command port from the serial front end (one cycle
 * per command) and signed telemetry readings in the units of each limit.
 * Status registers are write-one-to-clear; a set in the same cycle wins.
 * Latch-off ends only by clearing the overcurrent flag, or by reset.
 * pinstrapMode must be steady at the first edge after reset release.
 */
// Contract
// - Temperature at warn limit sets temp summary, OT warn bit, alert.
// - Temperature warning limit resets to 0x005F, that is 95 C.
// - Limits are Linear: 5-bit signed exponent, 11-bit signed mantissa.
// - Input overvoltage sets other, input, VIN-OV bits and alert.
// - VIN limit resets to 0x0011 (17 V); pinstrap mode gives 14 V.
// - Store-all rewrites VIN limit as its two LSBs plus 14.
// - Input current at limit sets other, input, IIN-OC bits and alert.
// - Input overcurrent latches output off, asserts regulator fault.
// - Status byte is the same storage as status word low byte.
`timescale 1ns/1ps
`include "pfm_cfg.svh"

module pfm_fault_limit_monitor (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           resetn,
  // Configuration strap
  input  wire logic           pinstrapMode,
  // Command port
  input  wire pfm_pkg::pfm_cmd_t  cmdReq,
  output pfm_pkg::pfm_rsp_t       cmdRsp,
  // Telemetry
  input  wire pfm_pkg::pfm_tele_t telemetry,
  // Outputs toward host and power stage
  output logic                host_alert_out,
  output logic                regulator_fault_out,
  output logic                outputDisabled
);
  import pfm_pkg::*;

  typedef struct packed {
    // Strap load pending until the first edge after release
    logic        strapDone;
    // Limit registers
    logic [15:0] otWarnLimit;
    logic [15:0] vinOvLimit;
    logic [15:0] iinOcLimit;
    // Status storage; the status byte is statusWord[7:0]
    logic [15:0] statusWord;
    logic [7:0]  statusInput;
    logic [7:0]  statusTemp;
    // Registered pins and read answer
    logic        alert;
    logic        regFault;
    logic        latchedOff;
    pfm_rsp_t    rsp;
  } pfm_state_t;

  pfm_state_t state_r;
  pfm_state_t state_nxt;

  // Linear word to a wide signed value; shift covers exponent -16..15
  function automatic logic signed [47:0] pfm_decode(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [47:0] m;
    e = w[`PFM_EXP_MSB:`PFM_EXP_LSB];
    m = 48'(signed'(w[`PFM_MANT_MSB:0]));
    if (e >= 0) begin
      pfm_decode = m <<< 5'(e);
    end else begin
      // Fraction dropped; readings carry no fraction either
      pfm_decode = m >>> 5'(-e);
    end
  endfunction

  // Reading reaches limit; readings are integers so fractions truncate
  function automatic logic pfm_reached(input logic signed [15:0] rd,
                                       input logic [15:0] lim);
    pfm_reached = $signed(48'(rd)) >= pfm_decode(lim);
  endfunction

  // Write-one-to-clear of one status byte
  function automatic logic [7:0] pfm_w1c(input logic [7:0] cur,
                                         input logic [7:0] clr);
    pfm_w1c = cur & ~clr;
  endfunction

  logic otWarnHit;
  logic vinOvHit;
  logic iinOcHit;
  logic wrCmd;
  logic rdCmd;

  always_comb begin
    // Limit comparisons, one per condition
    otWarnHit = pfm_reached(telemetry.temp, state_r.otWarnLimit);
    vinOvHit  = pfm_reached(telemetry.vin, state_r.vinOvLimit);
    iinOcHit  = pfm_reached(telemetry.iin, state_r.iinOcLimit);
    // Command strobes
    wrCmd     = cmdReq.valid && cmdReq.write;
    rdCmd     = cmdReq.valid && !cmdReq.write;

    state_nxt = state_r;

    // Limit writes and status write-one-to-clear first; sets override below
    if (wrCmd) begin
      unique case (cmdReq.code)
        `PFM_CMD_OT_WARN: begin
          state_nxt.otWarnLimit = cmdReq.wdata;
        end
        `PFM_CMD_VIN_OV: begin
          state_nxt.vinOvLimit = cmdReq.wdata;
        end
        `PFM_CMD_IIN_OC: begin
          state_nxt.iinOcLimit = cmdReq.wdata;
        end
        `PFM_CMD_STORE_ALL: begin
          // Two LSBs taken as unsigned, offset by 14 V
          state_nxt.vinOvLimit = `PFM_VIN_OV_BASE
            + {14'h0000, state_r.vinOvLimit[1:0]};
        end
        `PFM_CMD_STATUS_BYTE: begin
          state_nxt.statusWord[7:0] = pfm_w1c(state_r.statusWord[7:0],
                                              cmdReq.wdata[7:0]);
        end
        `PFM_CMD_STATUS_WORD: begin
          state_nxt.statusWord[15:8] = pfm_w1c(state_r.statusWord[15:8],
                                               cmdReq.wdata[15:8]);
          state_nxt.statusWord[7:0]  = pfm_w1c(state_r.statusWord[7:0],
                                               cmdReq.wdata[7:0]);
        end
        `PFM_CMD_STATUS_INPUT: begin
          state_nxt.statusInput = pfm_w1c(state_r.statusInput,
                                          cmdReq.wdata[7:0]);
        end
        `PFM_CMD_STATUS_TEMP: begin
          state_nxt.statusTemp = pfm_w1c(state_r.statusTemp,
                                         cmdReq.wdata[7:0]);
        end
        default: ;
      endcase
    end

    // Strap sampled once after release, never under the async reset;
    // placed after the writes so it beats a limit write on that edge
    if (!state_r.strapDone) begin
      state_nxt.strapDone = 1'b1;
      if (pinstrapMode) begin
        state_nxt.vinOvLimit = `PFM_VIN_OV_STRAP;
      end
    end

    // Hardware sets win over a clear in the same cycle
    if (otWarnHit) begin
      state_nxt.statusWord[`PFM_SB_TEMP]    = 1'b1;
      state_nxt.statusTemp[`PFM_ST_OT_WARN] = 1'b1;
    end
    if (vinOvHit) begin
      state_nxt.statusWord[`PFM_SB_OTHER]  = 1'b1;
      state_nxt.statusWord[`PFM_SW_INPUT]  = 1'b1;
      state_nxt.statusInput[`PFM_SI_VIN_OV] = 1'b1;
    end
    // Latch-off and the fault pin follow this flag
    if (iinOcHit) begin
      state_nxt.statusWord[`PFM_SB_OTHER]  = 1'b1;
      state_nxt.statusWord[`PFM_SW_INPUT]  = 1'b1;
      state_nxt.statusInput[`PFM_SI_IIN_OC] = 1'b1;
    end

    // Latch-off lasts until the overcurrent flag is cleared; no retry
    state_nxt.latchedOff = state_nxt.statusInput[`PFM_SI_IIN_OC];
    state_nxt.regFault   = state_nxt.statusInput[`PFM_SI_IIN_OC];
    // Alert follows any pending flag
    state_nxt.alert = |state_nxt.statusWord
                    | |state_nxt.statusInput
                    | |state_nxt.statusTemp;

    // Read answer is registered; unmapped codes answer zero
    state_nxt.rsp.valid = rdCmd;
    state_nxt.rsp.rdata = 16'h0000;
    if (rdCmd) begin
      unique case (cmdReq.code)
        `PFM_CMD_OT_WARN: begin
          state_nxt.rsp.rdata = state_r.otWarnLimit;
        end
        `PFM_CMD_VIN_OV: begin
          state_nxt.rsp.rdata = state_r.vinOvLimit;
        end
        `PFM_CMD_IIN_OC: begin
          state_nxt.rsp.rdata = state_r.iinOcLimit;
        end
        `PFM_CMD_STATUS_BYTE: begin
          state_nxt.rsp.rdata = {8'h00, state_r.statusWord[7:0]};
        end
        `PFM_CMD_STATUS_WORD: begin
          state_nxt.rsp.rdata = state_r.statusWord;
        end
        `PFM_CMD_STATUS_INPUT: begin
          state_nxt.rsp.rdata = {8'h00, state_r.statusInput};
        end
        `PFM_CMD_STATUS_TEMP: begin
          state_nxt.rsp.rdata = {8'h00, state_r.statusTemp};
        end
        default: state_nxt.rsp.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r             <= '0;
      state_r.otWarnLimit <= `PFM_OT_WARN_RST;
      state_r.vinOvLimit  <= `PFM_VIN_OV_RST;
      state_r.iinOcLimit  <= `PFM_IIN_OC_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cmdRsp              = state_r.rsp;
  assign host_alert_out      = state_r.alert;
  assign regulator_fault_out = state_r.regFault;
  assign outputDisabled      = state_r.latchedOff;

endmodule

/* File: rtl/pfm_pkg.sv */
/*
 * Types of the limit monitor: command request, answer and telemetry.
 * Assumes pfm_cfg.svh holds the numbers; this package holds shapes only.
 */
package pfm_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } pfm_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } pfm_rsp_t;

  typedef struct packed {
    logic signed [15:0] temp;
    logic signed [15:0] vin;
    logic signed [15:0] iin;
  } pfm_tele_t;

endpackage

/* File: testbench/pfm_chk.sv */
/* Port checker of the limit monitor.
   Assumes it is bound onto pfm_fault_limit_monitor. */
`timescale 1ns/1ps
module pfm_chk (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              resetn,
  // Command port
  input wire pfm_pkg::pfm_cmd_t cmdReq,
  input wire pfm_pkg::pfm_rsp_t cmdRsp,
  // Outputs
  input wire logic              host_alert_out,
  input wire logic              regulator_fault_out,
  input wire logic              outputDisabled
);
  import pfm_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire rdReq = cmdReq.valid && !cmdReq.write;
  wire wrReq = cmdReq.valid && cmdReq.write;
  wire clrIn = wrReq && cmdReq.code == 8'h7C;
  property p_rsp; rdReq |=> cmdRsp.valid; endproperty
  property p_norsp; !rdReq |=> !cmdRsp.valid; endproperty
  property p_zero; !cmdRsp.valid |-> cmdRsp.rdata == 16'h0000; endproperty
  property p_pair; regulator_fault_out == outputDisabled; endproperty
  property p_alert; regulator_fault_out |-> host_alert_out; endproperty
  property p_latch;
    regulator_fault_out && !clrIn |=> regulator_fault_out;
  endproperty
  property p_rel; $fell(regulator_fault_out) |-> $past(clrIn); endproperty
  property p_alfall; $fell(host_alert_out) |-> $past(wrReq); endproperty
  a_rsp: assert property (p_rsp) else $error("read without answer");
  a_norsp: assert property (p_norsp) else $error("stray answer");
  a_zero: assert property (p_zero) else $error("idle data set");
  a_pair: assert property (p_pair) else $error("fault off differ");
  a_alert: assert property (p_alert) else $error("no alert");
  a_latch: assert property (p_latch) else $error("latch lost");
  a_rel: assert property (p_rel) else $error("fault fell alone");
  a_alfall: assert property (p_alfall) else $error("alert fell");
  c_fault: cover property (regulator_fault_out);
  c_rsp: cover property (cmdRsp.valid);
  c_alclr: cover property ($fell(host_alert_out));
endmodule
bind pfm_fault_limit_monitor pfm_chk i_pfm_chk (.core_clk, .resetn,
  .cmdReq, .cmdRsp, .host_alert_out, .regulator_fault_out, .outputDisabled);

/* File: testbench/pfm_host.sv */
/* Host model: issues commands on the command port.
   Assumes the bench calls cmd() and drives telemetry itself. */
`timescale 1ns/1ps
module pfm_host (
  // Clock
  input wire logic           core_clk,
  // Command port
  output pfm_pkg::pfm_cmd_t  cmdReq
);
  import pfm_pkg::*;
  initial cmdReq = '0;
  task automatic cmd(input logic wr, input logic [7:0] c,
                     input logic [15:0] d);
    @(negedge core_clk);
    cmdReq <= '{1'b1, wr, c, d};
    @(negedge core_clk);
    // Released fields scrambled, never left showing old values
    cmdReq <= '{1'b0, ~wr, ~c, ~d};
  endtask
endmodule

/* File: testbench/tb_top.sv */
/* Self-checking bench of the limit monitor.
   Assumes the host model and the checker are compiled alongside. */
`timescale 1ns/1ps
module tb_top;
  import pfm_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        strap = 1'b0;
  pfm_cmd_t    cmdReq;
  pfm_rsp_t    cmdRsp;
  pfm_tele_t   tele = '0;
  logic        alert, fault, off;
  int          n_fail = 0;
  int          cmp_count = 0;
  logic [15:0] expQ[$];
  always #10 core_clk = ~core_clk;
  pfm_host i_pfm_host (.core_clk(core_clk), .cmdReq(cmdReq));
  pfm_fault_limit_monitor i_pfm_fault_limit_monitor (.core_clk(core_clk),
    .resetn(resetn), .pinstrapMode(strap), .cmdReq(cmdReq),
    .cmdRsp(cmdRsp), .telemetry(tele), .host_alert_out(alert),
    .regulator_fault_out(fault), .outputDisabled(off));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    expQ.push_back(e);
    i_pfm_host.cmd(1'b0, c, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_pfm_host.cmd(1'b1, c, d);
  endtask
  // Alert, fault, off once the flags had time to land
  task automatic pins(input logic [2:0] e);
    repeat (2) @(negedge core_clk);
    cmp({13'h0000, alert, fault, off}, {13'h0000, e});
  endtask
  // Answers arrive in request order; an unasked answer never matches
  // Sampled mid-cycle, away from the edge that launches the answer
  always @(negedge core_clk)
    if (cmdRsp.valid === 1'b1)
      cmp(cmdRsp.rdata, expQ.size() ? expQ.pop_front() : 16'hxxxx);
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [15:0] v;
    logic [15:0] l;
    void'($urandom(58));
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    repeat (2) @(negedge core_clk);
    rd(8'h51, 16'h005F);
    rd(8'h55, 16'h0011);
    rd(8'h5B, 16'h00FF);
    rd(8'h42, 16'h0000);
    // Positive limit, so an idle zero reading never trips it
    v = {1'b0, 4'($urandom), 1'b0, 10'($urandom) | 10'h001};
    wr(8'h5B, v);
    rd(8'h5B, v);
    wr(8'h5B, 16'h00FF);
    wr(8'h55, v);
    wr(8'h11, 16'h0000);
    l = 16'h000E + {14'h0000, v[1:0]};
    rd(8'h55, l);
    tele.temp = 16'h005E;
    pins(3'b000);
    tele.temp = 16'h005F;
    pins(3'b100);
    rd(8'h7D, 16'h0040);
    rd(8'h79, 16'h0004);
    tele.temp = '0;
    wr(8'h7D, 16'h0040);
    wr(8'h78, 16'h0004);
    pins(3'b000);
    wr(8'h51, 16'h0830);
    tele.temp = 16'h005F;
    pins(3'b000);
    tele.temp = 16'h0060;
    pins(3'b100);
    tele.temp = '0;
    wr(8'h7D, 16'h0040);
    wr(8'h78, 16'h0004);
    tele.vin = l - 16'h0001;
    pins(3'b000);
    tele.vin = l;
    pins(3'b100);
    rd(8'h7C, 16'h0080);
    rd(8'h79, 16'h2001);
    rd(8'h78, 16'h0001);
    tele.vin = '0;
    wr(8'h7C, 16'h0080);
    wr(8'h79, 16'h2001);
    pins(3'b000);
    tele.iin = 16'h00FF;
    pins(3'b111);
    rd(8'h7C, 16'h0004);
    wr(8'h7C, 16'h0004);
    pins(3'b111);
    tele.iin = '0;
    pins(3'b111);
    wr(8'h7C, 16'h0004);
    pins(3'b100);
    wr(8'h79, 16'h2001);
    pins(3'b000);
    // Reset in mid-run with a latched fault, strap set for the release
    tele.iin = 16'h00FF;
    pins(3'b111);
    strap = 1'b1;
    resetn = 1'b0;
    tele.iin = '0;
    pins(3'b000);
    resetn = 1'b1;
    rd(8'h55, 16'h000E);
    rd(8'h51, 16'h005F);
    repeat (2) @(negedge core_clk);
    cmp(16'(expQ.size()), 16'h0000);
    finish_test();
  end
  // Run needs about a hundred cycles; a hang is cut well beyond that
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule
